// *** ldp_param_map.v ***
// Laser driver parameter map: decoded serial requests, limits, device state and nonvolatile save sequencing
//
// Overview of operation
// - Writing pulse frequency recomputes the maximum pulse duration at once.
// - Pulse duration stays between 2 ms and period minus 2 ms.
// - Pulse duration never exceeds 5000 ms, which binds at low frequencies.
// - Frequency zero selects continuous output, nonzero selects long-pulse output.
// - Out-of-range writes store the nearest limit instead of being refused.
// - Any device-state write other than start clears the started state; under external enable the output follows the enable input.
// - Exclusive state requests are refused; start is refused under external enable.
// - Start followed directly by stop saves retained parameters to nonvolatile memory.
// - Saving lasts about 300 ms and all requests are ignored meanwhile.
// - Retained: frequency, duration, current with limits, calibration, thermistor limits, beta, extension.
// - Device-state writes are command codes for start, stop, sources, enable, interlocks.
// - Device-state reads give a bit mask with bit 0 always set.
// - Lock flags report interlock, over-current, overheat, thermistor interlock; overheat at warning.
// - Over-temperature protection sets overheat and over-current flags together.
// - Calibration in 0.01 percent, default 2710h, range 251Ch to 2904h.
// - Unknown parameter numbers answer parameter zero with value zero.
// - Malformed commands answer with error code 0001.
// - Values are scaled integers in 0.1 Hz, 0.1 ms, mA, V and degree units.
// - Station address is readable and writable, default 0064h.
// - A get answers with the parameter number and its current value.
// - Set commands get no answer unless the extension enables it or the parameter number is unknown.
// - Every parameter is sixteen bits wide.
// - Reset selects external current set, external enable and allowed interlock.
`timescale 1ns/10ps
`include "ldp_regs.vh"

module ldp_param_map #(
  parameter [15:0] FREQ_MIN = 16'h0000,
  parameter [15:0] FREQ_MAX = 16'h03E8,
  parameter [15:0] CURRENT_MIN = 16'h0000,
  parameter [15:0] CURRENT_CEILING = 16'h0FA0,
  parameter [15:0] OC_THRESHOLD = 16'h1000,
  parameter [15:0] BOARD_WARN = 16'h0320,
  parameter [15:0] SERIAL_NUMBER = 16'h1234, // Arbitrary value
  parameter [31:0] SAVE_CYCLES = `LDP_SAVE_MS * (`LDP_CLK_HZ / 1000)
) (
  // Clock, reset, enable
  input wire clock_i,
  input wire rst_i,
  input wire ce_i,
  // Decoded request from the serial front end
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire cmd_malformed_i,
  input wire [15:0] cmd_param_i,
  input wire [15:0] cmd_data_i,
  output reg cmd_ready_o,
  // Answer to the serial front end
  output reg rsp_valid_o,
  output reg rsp_error_o,
  output reg [15:0] rsp_param_o,
  output reg [15:0] rsp_data_o,
  // Measurements and protection inputs
  input wire [15:0] meas_current_i,
  input wire [15:0] meas_voltage_i,
  input wire [15:0] meas_thermistor_i,
  input wire [15:0] meas_board_i,
  input wire interlock_i,
  input wire thermistor_interlock_i,
  input wire overcurrent_i,
  input wire overtemp_protect_i,
  input wire ext_enable_i,
  // Settings to the power stage
  output reg [15:0] pulse_frequency_o,
  output reg [15:0] pulse_duration_o,
  output reg [15:0] output_current_o,
  output reg [15:0] current_calibration_o,
  output reg continuous_output_o,
  output reg laser_enable_o,
  output reg int_current_o,
  // Nonvolatile store
  output reg nv_store_o,
  output reg nv_busy_o
);

  // Scaled to 0.1 ms as integers, then cut on purpose to the widths the limit logic uses
  localparam integer GUARD_I = 10 * `LDP_DUR_GUARD_MS;
  localparam integer CAP_I = 10 * `LDP_DUR_CAP_MS;
  localparam [16:0] GUARD = GUARD_I[16:0];
  localparam [15:0] DUR_CAP = CAP_I[15:0];
  localparam [15:0] DUR_MIN = GUARD_I[15:0];

  // Save sequencer states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SAVE = 2'b10;

  // Clamp to a limit pair rather than refusing
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Paired codes: one half selects, both halves or neither keep the old choice
  function pair_sel;
    input old;
    input [15:0] d;
    input [15:0] set_c;
    input [15:0] clr_c;
    pair_sel = ((d & (set_c | clr_c)) == set_c) ? 1'b1 : (((d & (set_c | clr_c)) == clr_c) ? 1'b0 : old);
  endfunction

  // Longest duration for a frequency, in 0.1 ms
  function [15:0] dur_limit;
    input [15:0] f;
    reg [16:0] per;
    begin
      per = 17'd0;
      if (f == 16'h0000) begin
        dur_limit = DUR_CAP;
      end else begin
        per = `LDP_PERIOD_NUM / {1'b0, f};
        if (per < GUARD + {1'b0, DUR_MIN}) begin
          dur_limit = DUR_MIN;
        end else if (per - GUARD > {1'b0, DUR_CAP}) begin
          dur_limit = DUR_CAP;
        end else begin
          dur_limit = per[15:0] - GUARD[15:0];
        end
      end
    end
  endfunction

  // Parameter storage, all sixteen bits wide
  reg [15:0] freq_q;
  reg [15:0] dur_q;
  reg [15:0] dur_max_q;
  reg [15:0] cur_q;
  reg [15:0] cur_max_q;
  reg [15:0] cal_q;
  reg [15:0] th_lo_q;
  reg [15:0] th_hi_q;
  reg [15:0] beta_q;
  reg [15:0] ext_q;
  reg [15:0] station_q;
  // Device state bits
  reg started_q;
  reg int_cur_q;
  reg int_en_q;
  reg th_deny_q;
  reg il_deny_q;
  reg start_seen_q;
  // Save sequencer
  reg [1:0] state_q;
  reg [31:0] save_cnt_q;

  wire take = ce_i & cmd_valid_i & (state_q == ST_IDLE);
  wire wr = take & cmd_write_i & ~cmd_malformed_i;
  wire state_wr = wr & (cmd_param_i == `LDP_DEVICE_STATE);
  wire save_req = (state_wr & start_seen_q & (cmd_data_i == `LDP_CMD_STOP)) |
                  (wr & (cmd_param_i == `LDP_STORE_SETTINGS));
  wire [15:0] new_dur_max = dur_limit(clamp(cmd_data_i, FREQ_MIN, FREQ_MAX));

  // Status word and lock word, built live
  wire [15:0] state_word = {8'h00, il_deny_q, th_deny_q, 1'b0, int_en_q, 1'b0, int_cur_q,
                            started_q, 1'b1};
  wire board_hot = meas_board_i >= BOARD_WARN;
  wire [15:0] lock_word = {10'h000, thermistor_interlock_i, board_hot | overtemp_protect_i,
                           overcurrent_i | overtemp_protect_i, 1'b0, interlock_i, 1'b0};
  wire fault = (interlock_i & ~il_deny_q) | (thermistor_interlock_i & ~th_deny_q) |
               overcurrent_i | overtemp_protect_i;

  // Read multiplexer; values are the stored scaled integers
  reg [15:0] rd_data;
  reg rd_known;
  always @* begin
    rd_known = 1'b1;
    case (cmd_param_i)
      `LDP_PULSE_FREQUENCY: rd_data = freq_q;
      `LDP_PULSE_FREQUENCY_MIN: rd_data = FREQ_MIN;
      `LDP_PULSE_FREQUENCY_MAX: rd_data = FREQ_MAX;
      `LDP_PULSE_DURATION: rd_data = dur_q;
      `LDP_PULSE_DURATION_MIN: rd_data = DUR_MIN;
      `LDP_PULSE_DURATION_MAX: rd_data = dur_max_q;
      `LDP_OUTPUT_CURRENT: rd_data = cur_q;
      `LDP_OUTPUT_CURRENT_MIN: rd_data = CURRENT_MIN;
      `LDP_OUTPUT_CURRENT_MAX: rd_data = cur_max_q;
      `LDP_OUTPUT_CURRENT_CEILING: rd_data = CURRENT_CEILING;
      `LDP_OUTPUT_CURRENT_MEASURED: rd_data = meas_current_i;
      `LDP_OVERCURRENT_THRESHOLD: rd_data = OC_THRESHOLD;
      `LDP_CURRENT_CALIBRATION: rd_data = cal_q;
      `LDP_OUTPUT_VOLTAGE_MEASURED: rd_data = meas_voltage_i;
      `LDP_DEVICE_STATE: rd_data = state_word;
      `LDP_UNIT_SERIAL: rd_data = SERIAL_NUMBER;
      `LDP_PROTO_EXT: rd_data = ext_q;
      `LDP_STATION_ADDRESS: rd_data = station_q;
      `LDP_LOCK_FLAGS: rd_data = lock_word;
      `LDP_THERMISTOR_LOW_LIMIT: rd_data = th_lo_q;
      `LDP_THERMISTOR_HIGH_LIMIT: rd_data = th_hi_q;
      `LDP_THERMISTOR_TEMP_MEASURED: rd_data = meas_thermistor_i;
      `LDP_BOARD_TEMP_MEASURED: rd_data = meas_board_i;
      `LDP_THERMISTOR_BETA: rd_data = beta_q;
      `LDP_STORE_SETTINGS, `LDP_RESTORE_SETTINGS: rd_data = 16'h0000; // Write-only entries read as zero
      default: begin
        rd_data = 16'h0000;
        rd_known = 1'b0;
      end
    endcase
  end

  // Parameter writes; the restore entry returns the retained set to its reset values
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      freq_q <= 16'h0000;
      dur_q <= 16'h0014;
      dur_max_q <= 16'hC350;
      cur_q <= 16'h0000;
      cur_max_q <= 16'h0000;
      cal_q <= `LDP_CAL_RESET;
      th_lo_q <= 16'h0000;
      th_hi_q <= 16'h0000;
      beta_q <= 16'h0000;
      ext_q <= `LDP_EXT_RESET;
      station_q <= `LDP_STATION_RESET;
    end else if (wr) begin
      case (cmd_param_i)
        `LDP_PULSE_FREQUENCY: begin
          freq_q <= clamp(cmd_data_i, FREQ_MIN, FREQ_MAX);
          dur_max_q <= new_dur_max;
          dur_q <= clamp(dur_q, DUR_MIN, new_dur_max);
        end
        `LDP_PULSE_DURATION: dur_q <= clamp(cmd_data_i, DUR_MIN, dur_max_q);
        `LDP_OUTPUT_CURRENT: cur_q <= clamp(cmd_data_i, CURRENT_MIN, cur_max_q);
        `LDP_OUTPUT_CURRENT_MAX: begin
          cur_max_q <= clamp(cmd_data_i, CURRENT_MIN, CURRENT_CEILING);
          cur_q <= clamp(cur_q, CURRENT_MIN, clamp(cmd_data_i, CURRENT_MIN, CURRENT_CEILING));
        end
        `LDP_CURRENT_CALIBRATION: cal_q <= clamp(cmd_data_i, `LDP_CAL_MIN, `LDP_CAL_MAX);
        `LDP_THERMISTOR_LOW_LIMIT: th_lo_q <= cmd_data_i;
        `LDP_THERMISTOR_HIGH_LIMIT: th_hi_q <= cmd_data_i;
        `LDP_THERMISTOR_BETA: beta_q <= cmd_data_i;
        `LDP_STATION_ADDRESS: station_q <= cmd_data_i;
        `LDP_PROTO_EXT: begin
          // Extension takes codes, not values; baud codes land in bits 5:3
          if (cmd_data_i == `LDP_EXT_CS_ON) begin
            ext_q[`LDP_EXT_CS_BIT] <= 1'b1;
          end else if (cmd_data_i == `LDP_EXT_CS_OFF) begin
            ext_q[`LDP_EXT_CS_BIT] <= 1'b0;
          end else if (cmd_data_i == `LDP_EXT_REPLY_ON) begin
            ext_q[`LDP_EXT_REPLY_BIT] <= 1'b1;
          end else if (cmd_data_i == `LDP_EXT_REPLY_OFF) begin
            ext_q[`LDP_EXT_REPLY_BIT] <= 1'b0;
          end else if (cmd_data_i[15:8] == 8'h01 && cmd_data_i[4:0] == 5'h00 && cmd_data_i[7:5] != 3'h7) begin
            ext_q[`LDP_EXT_BAUD_LSB+2:`LDP_EXT_BAUD_LSB] <= cmd_data_i[7:5];
          end
        end
        `LDP_RESTORE_SETTINGS: begin
          freq_q <= 16'h0000;
          dur_q <= 16'h0014;
          dur_max_q <= 16'hC350;
          cur_q <= 16'h0000;
          cur_max_q <= 16'h0000;
          cal_q <= `LDP_CAL_RESET;
          th_lo_q <= 16'h0000;
          th_hi_q <= 16'h0000;
          beta_q <= 16'h0000;
          ext_q <= `LDP_EXT_RESET;
        end
        default: ;
      endcase
    end
  end

  // Device-state commands; a mixed word applies each selection code it carries but never starts
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      started_q <= 1'b0;
      int_cur_q <= 1'b0;
      int_en_q <= 1'b0;
      il_deny_q <= 1'b0;
      th_deny_q <= 1'b0;
    end else if (state_wr) begin
      // Both halves of a pair at once are refused, so the old choice stays
      int_cur_q <= pair_sel(int_cur_q, cmd_data_i, `LDP_CMD_INT_CURRENT, `LDP_CMD_EXT_CURRENT);
      int_en_q <= pair_sel(int_en_q, cmd_data_i, `LDP_CMD_INT_ENABLE, `LDP_CMD_EXT_ENABLE);
      il_deny_q <= pair_sel(il_deny_q, cmd_data_i, `LDP_CMD_DENY_IL, `LDP_CMD_ALLOW_IL);
      th_deny_q <= pair_sel(th_deny_q, cmd_data_i, `LDP_CMD_DENY_TH_IL, `LDP_CMD_ALLOW_TH_IL);
      // Only a bare start under internal enable starts; anything else stops
      started_q <= (cmd_data_i == `LDP_CMD_START) & int_en_q;
    end
  end

  // Remember whether the last accepted request was a start code
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      start_seen_q <= 1'b0;
    end else if (take) begin
      start_seen_q <= state_wr & (cmd_data_i == `LDP_CMD_START);
    end
  end

  // Save sequencer: inputs are shut out for the whole save
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      save_cnt_q <= 32'h0000_0000;
      nv_store_o <= 1'b0;
      nv_busy_o <= 1'b0;
      cmd_ready_o <= 1'b1;
    end else if (ce_i) begin
      nv_store_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (save_req) begin
            state_q <= ST_SAVE;
            save_cnt_q <= SAVE_CYCLES - 32'h0000_0001;
            nv_store_o <= 1'b1;
            nv_busy_o <= 1'b1;
            cmd_ready_o <= 1'b0;
          end
        end
        ST_SAVE: begin
          if (save_cnt_q == 32'h0000_0000) begin
            state_q <= ST_IDLE;
            nv_busy_o <= 1'b0;
            cmd_ready_o <= 1'b1;
          end else begin
            save_cnt_q <= save_cnt_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          nv_busy_o <= 1'b0;
          cmd_ready_o <= 1'b1;
        end
      endcase
    end
  end

  // Answers: get always answers, set only with reply mode or unknown number
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_error_o <= 1'b0;
      rsp_param_o <= 16'h0000;
      rsp_data_o <= 16'h0000;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      if (take) begin
        if (cmd_malformed_i) begin
          rsp_valid_o <= 1'b1;
          rsp_error_o <= 1'b1;
          rsp_param_o <= 16'h0000;
          rsp_data_o <= `LDP_ERR_MALFORMED;
        end else if (!rd_known) begin
          rsp_valid_o <= 1'b1;
          rsp_error_o <= 1'b0;
          rsp_param_o <= 16'h0000;
          rsp_data_o <= 16'h0000;
        end else if (!cmd_write_i) begin
          rsp_valid_o <= 1'b1;
          rsp_error_o <= 1'b0;
          rsp_param_o <= cmd_param_i;
          rsp_data_o <= rd_data;
        end else if (ext_q[`LDP_EXT_REPLY_BIT]) begin
          // Reply carries the raw written word; the clamped value is read back by a get
          rsp_valid_o <= 1'b1;
          rsp_error_o <= 1'b0;
          rsp_param_o <= cmd_param_i;
          rsp_data_o <= cmd_data_i;
        end
      end
    end
  end

  // Registered settings to the power stage; faults hold the output off
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_frequency_o <= 16'h0000;
      pulse_duration_o <= 16'h0014;
      output_current_o <= 16'h0000;
      current_calibration_o <= `LDP_CAL_RESET;
      continuous_output_o <= 1'b1;
      laser_enable_o <= 1'b0;
      int_current_o <= 1'b0;
    end else if (ce_i) begin
      pulse_frequency_o <= freq_q;
      pulse_duration_o <= dur_q;
      output_current_o <= cur_q;
      current_calibration_o <= cal_q;
      continuous_output_o <= (freq_q == 16'h0000);
      laser_enable_o <= (int_en_q ? started_q : ext_enable_i) & ~fault;
      int_current_o <= int_cur_q;
    end
  end

endmodule // ldp_param_map

// *** ldp_regs.vh ***
// Parameter numbers, field positions, codes, reset values and timing for the laser driver parameter map
`ifndef LDP_REGS_VH
`define LDP_REGS_VH

// Parameter numbers on the text serial protocol
`define LDP_PULSE_FREQUENCY 16'h0100
`define LDP_PULSE_FREQUENCY_MIN 16'h0101
`define LDP_PULSE_FREQUENCY_MAX 16'h0102
`define LDP_PULSE_DURATION 16'h0200
`define LDP_PULSE_DURATION_MIN 16'h0201
`define LDP_PULSE_DURATION_MAX 16'h0202
`define LDP_OUTPUT_CURRENT 16'h0300
`define LDP_OUTPUT_CURRENT_MIN 16'h0301
`define LDP_OUTPUT_CURRENT_MAX 16'h0302
`define LDP_OUTPUT_CURRENT_CEILING 16'h0306
`define LDP_OUTPUT_CURRENT_MEASURED 16'h0307
`define LDP_OVERCURRENT_THRESHOLD 16'h0308
`define LDP_CURRENT_CALIBRATION 16'h030E
`define LDP_OUTPUT_VOLTAGE_MEASURED 16'h0407
`define LDP_DEVICE_STATE 16'h0700
`define LDP_UNIT_SERIAL 16'h0701
`define LDP_PROTO_EXT 16'h0704
`define LDP_STATION_ADDRESS 16'h0720
`define LDP_LOCK_FLAGS 16'h0800
`define LDP_STORE_SETTINGS 16'h0900
`define LDP_RESTORE_SETTINGS 16'h0901
`define LDP_THERMISTOR_LOW_LIMIT 16'h0A05
`define LDP_THERMISTOR_HIGH_LIMIT 16'h0A06
`define LDP_THERMISTOR_TEMP_MEASURED 16'h0AE4
`define LDP_BOARD_TEMP_MEASURED 16'h0AF4
`define LDP_THERMISTOR_BETA 16'h0B0E

// Device-state command codes
`define LDP_CMD_START 16'h0008
`define LDP_CMD_STOP 16'h0010
`define LDP_CMD_INT_CURRENT 16'h0020
`define LDP_CMD_EXT_CURRENT 16'h0040
`define LDP_CMD_EXT_ENABLE 16'h0200
`define LDP_CMD_INT_ENABLE 16'h0400
`define LDP_CMD_ALLOW_IL 16'h1000
`define LDP_CMD_DENY_IL 16'h2000
`define LDP_CMD_DENY_TH_IL 16'h4000
`define LDP_CMD_ALLOW_TH_IL 16'h8000

// Protocol extension command codes and field positions
`define LDP_EXT_CS_ON 16'h0002
`define LDP_EXT_CS_OFF 16'h0004
`define LDP_EXT_REPLY_ON 16'h0008
`define LDP_EXT_REPLY_OFF 16'h0010
`define LDP_EXT_CS_BIT 1
`define LDP_EXT_REPLY_BIT 2
`define LDP_EXT_BAUD_LSB 3
`define LDP_EXT_RESET 16'h0029

// Reset values and fixed limits (ms, 0.01 %)
`define LDP_CAL_RESET 16'h2710
`define LDP_CAL_MIN 16'h251C
`define LDP_CAL_MAX 16'h2904
`define LDP_STATION_RESET 16'h0064
`define LDP_DUR_GUARD_MS 2
`define LDP_DUR_CAP_MS 5000
`define LDP_PERIOD_NUM 17'h1_86A0
`define LDP_ERR_MALFORMED 16'h0001

// Timing
`define LDP_CLK_HZ 100000000
`define LDP_SAVE_MS 300

`endif

// *** ldp_checker_properties.sv ***
// Checker for the laser driver parameter map ports
`timescale 1ns/10ps
module ldp_checker #(
  parameter [31:0] SAVE_CYCLES = 32'h0000_0014
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Request and answer
  input wire ce_i,
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire cmd_ready_o,
  input wire rsp_valid_o,
  // Settings and save
  input wire [15:0] pulse_frequency_o,
  input wire [15:0] pulse_duration_o,
  input wire [15:0] current_calibration_o,
  input wire continuous_output_o,
  input wire nv_store_o,
  input wire nv_busy_o
);
  reg [31:0] busy_cnt_q;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // Save length counter; holds while the enable freezes the block
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      busy_cnt_q <= 32'h0000_0000;
    else if (ce_i)
      busy_cnt_q <= nv_busy_o ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
  end
  property p_get_answer;
    ce_i && cmd_valid_i && !cmd_write_i && cmd_ready_o |=> rsp_valid_o;
  endproperty
  a_get_answer: assert property (p_get_answer) else $error("get not answered");
  property p_answer_cause;
    rsp_valid_o |-> $past(cmd_valid_i && cmd_ready_o && ce_i);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without request");
  property p_mode;
    continuous_output_o == (pulse_frequency_o == 16'h0000);
  endproperty
  a_mode: assert property (p_mode) else $error("output mode wrong");
  property p_dur_floor;
    pulse_duration_o >= 16'h0014;
  endproperty
  a_dur_floor: assert property (p_dur_floor) else $error("duration too short");
  property p_dur_cap;
    pulse_duration_o <= 16'hC350;
  endproperty
  a_dur_cap: assert property (p_dur_cap) else $error("duration too long");
  property p_cal_range;
    current_calibration_o >= 16'h251C && current_calibration_o <= 16'h2904;
  endproperty
  a_cal_range: assert property (p_cal_range) else $error("calibration out of range");
  property p_store;
    nv_store_o |-> nv_busy_o && !cmd_ready_o ##1 !nv_store_o;
  endproperty
  a_store: assert property (p_store) else $error("store pulse wrong");
  property p_busy_refuse;
    nv_busy_o |-> !cmd_ready_o;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("ready while saving");
  property p_busy_len;
    $fell(nv_busy_o) |-> busy_cnt_q == SAVE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("save length wrong");
endmodule // ldp_checker
bind ldp_param_map ldp_checker #(.SAVE_CYCLES(SAVE_CYCLES)) i_ldp_checker (
  .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
  .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .pulse_frequency_o(pulse_frequency_o),
  .pulse_duration_o(pulse_duration_o), .current_calibration_o(current_calibration_o),
  .continuous_output_o(continuous_output_o), .nv_store_o(nv_store_o), .nv_busy_o(nv_busy_o)
);

// *** ldp_host.sv ***
// Host model issuing decoded requests
`timescale 1ns/10ps
module ldp_host (
  // Clock and device status
  input wire clock_i,
  input wire cmd_ready_i,
  input wire rsp_valid_i,
  // Decoded request
  output reg cmd_valid_o,
  output reg cmd_write_o,
  output reg cmd_malformed_o,
  output reg [15:0] cmd_param_o,
  output reg [15:0] cmd_data_o
);
  // Idle fields carry junk so a stale value is never trusted
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_malformed_o = 1'b0;
    cmd_param_o = 16'hA5A5;
    cmd_data_o = 16'h5A5A;
  end
  // One request per call on falling edges; an idle cycle follows so strobes never toggle twice
  task xfer(input w, input m, input [15:0] p, input [15:0] d, input wt, output got);
    int n;
    n = 0;
    while (wt && cmd_ready_i !== 1'b1 && n < 100) begin // Hold off while saving
      @(negedge clock_i);
      n++;
    end
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_malformed_o = m;
    cmd_param_o = p; // Codes and scaled values
    cmd_data_o = d;
    @(negedge clock_i);
    got = rsp_valid_i;
    cmd_valid_o = 1'b0;
    cmd_param_o = ~p;
    cmd_data_o = ~d;
    @(negedge clock_i);
  endtask
endmodule // ldp_host

// *** tb.sv ***
// Self-checking testbench for the laser driver parameter map
`timescale 1ns/10ps
`include "ldp_regs.vh"
module tb;
  reg clock_i;
  reg rst_i;
  reg il, til, oc, ot, ce;
  reg [15:0] mc, mb;
  wire cv, cw, cm, rdy, rv, re, cont, busy, le, ic;
  wire [15:0] cp, cd, rp, rd, ocur;
  int failures = 0;
  int cmp_count = 0;
  // Short save keeps the run brief
  ldp_param_map #(.SAVE_CYCLES(32'h0000_0014)) i_ldp_param_map (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_malformed_i(cm), .cmd_param_i(cp), .cmd_data_i(cd), .cmd_ready_o(rdy), .rsp_valid_o(rv),
    .rsp_error_o(re), .rsp_param_o(rp), .rsp_data_o(rd), .meas_current_i(mc), .meas_voltage_i(mc),
    .meas_thermistor_i(mc), .meas_board_i(mb), .interlock_i(il), .thermistor_interlock_i(til),
    .overcurrent_i(oc), .overtemp_protect_i(ot), .ext_enable_i(1'b0), .pulse_frequency_o(),
    .pulse_duration_o(), .output_current_o(ocur), .current_calibration_o(), .continuous_output_o(cont),
    .laser_enable_o(le), .int_current_o(ic), .nv_store_o(), .nv_busy_o(busy)
  );
  ldp_host i_ldp_host (
    .clock_i(clock_i), .cmd_ready_i(rdy), .rsp_valid_i(rv), .cmd_valid_o(cv), .cmd_write_o(cw),
    .cmd_malformed_o(cm), .cmd_param_o(cp), .cmd_data_o(cd)
  );
  task chk(input [15:0] g, input [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Get expects a value answer naming the parameter
  task get(input [15:0] p, input [15:0] e);
    logic g;
    i_ldp_host.xfer(1'b0, 1'b0, p, 16'h0000, 1'b1, g);
    chk({15'h0000, g}, 16'h0001);
    chk(rp, p);
    chk(rd, e);
  endtask
  task put(input [15:0] p, input [15:0] d, input eg);
    logic g;
    i_ldp_host.xfer(1'b1, 1'b0, p, d, 1'b1, g);
    chk({15'h0000, g}, {15'h0000, eg});
  endtask
  task s_defaults;
    get(`LDP_CURRENT_CALIBRATION, 16'h2710);
    get(`LDP_STATION_ADDRESS, 16'h0064);
    get(`LDP_DEVICE_STATE, 16'h0001);
    get(`LDP_PULSE_DURATION_MAX, 16'hC350);
  endtask
  task s_limits;
    put(`LDP_CURRENT_CALIBRATION, 16'h0000, 1'b0);
    get(`LDP_CURRENT_CALIBRATION, 16'h251C);
    put(`LDP_CURRENT_CALIBRATION, 16'hFFFF, 1'b0);
    get(`LDP_CURRENT_CALIBRATION, 16'h2904);
    put(`LDP_STATION_ADDRESS, 16'h0042, 1'b0);
    get(`LDP_STATION_ADDRESS, 16'h0042);
  endtask
  task s_pulse;
    put(`LDP_PULSE_FREQUENCY, 16'hFFFF, 1'b0);
    get(`LDP_PULSE_FREQUENCY, 16'h03E8);
    get(`LDP_PULSE_DURATION_MAX, 16'h0050);
    put(`LDP_PULSE_DURATION, 16'hFFFF, 1'b0);
    get(`LDP_PULSE_DURATION, 16'h0050);
    chk({15'h0000, cont}, 16'h0000);
    put(`LDP_PULSE_DURATION, 16'h0000, 1'b0);
    get(`LDP_PULSE_DURATION, 16'h0014);
    put(`LDP_PULSE_FREQUENCY, 16'h0001, 1'b0);
    get(`LDP_PULSE_DURATION_MAX, 16'hC350);
    put(`LDP_PULSE_FREQUENCY, 16'h0000, 1'b0);
    chk({15'h0000, cont}, 16'h0001);
  endtask
  // Each of the eight pair codes once, then a start; the first four build the mask, the rest undo it
  task s_state;
    logic [15:0] c [0:7];
    c = '{16'h0400, 16'h0020, 16'h2000, 16'h4000, 16'h0200, 16'h0040, 16'h1000, 16'h8000};
    for (int i = 0; i < 8; i++) begin
      put(`LDP_DEVICE_STATE, c[i], 1'b0);
      if (i == 3) begin
        get(`LDP_DEVICE_STATE, 16'h00D5);
        chk({15'h0000, ic}, 16'h0001);
      end
    end
    get(`LDP_DEVICE_STATE, 16'h0001);
    put(`LDP_DEVICE_STATE, `LDP_CMD_START, 1'b0);
    get(`LDP_DEVICE_STATE, 16'h0001);
  endtask
  task s_save;
    logic g;
    put(`LDP_DEVICE_STATE, `LDP_CMD_INT_ENABLE, 1'b0);
    put(`LDP_DEVICE_STATE, `LDP_CMD_START, 1'b0);
    get(`LDP_DEVICE_STATE, 16'h0013);
    chk({15'h0000, le}, 16'h0001);
    put(`LDP_DEVICE_STATE, `LDP_CMD_START, 1'b0);
    put(`LDP_DEVICE_STATE, `LDP_CMD_STOP, 1'b0);
    chk({15'h0000, busy}, 16'h0001);
    chk({15'h0000, rdy}, 16'h0000);
    i_ldp_host.xfer(1'b0, 1'b0, `LDP_DEVICE_STATE, 16'h0000, 1'b0, g);
    chk({15'h0000, g}, 16'h0000);
    get(`LDP_DEVICE_STATE, 16'h0011);
    chk({15'h0000, le}, 16'h0000);
    put(`LDP_STORE_SETTINGS, 16'h0000, 1'b0);
    chk({15'h0000, busy}, 16'h0001);
    put(`LDP_PULSE_FREQUENCY, 16'h03E8, 1'b0);
    put(`LDP_RESTORE_SETTINGS, 16'h0000, 1'b0);
    get(`LDP_PULSE_FREQUENCY, 16'h0000);
    get(`LDP_CURRENT_CALIBRATION, 16'h2710);
  endtask
  task s_errors;
    logic g;
    i_ldp_host.xfer(1'b0, 1'b0, 16'h0555, 16'h0000, 1'b1, g);
    chk({15'h0000, g}, 16'h0001);
    chk(rp, 16'h0000);
    chk(rd, 16'h0000);
    i_ldp_host.xfer(1'b0, 1'b1, `LDP_PULSE_FREQUENCY, 16'h0000, 1'b1, g);
    chk({15'h0000, g}, 16'h0001);
    chk({15'h0000, re}, 16'h0001);
    chk(rd, `LDP_ERR_MALFORMED);
    // Enable low freezes the map, so even a get goes unanswered
    ce = 1'b0;
    i_ldp_host.xfer(1'b0, 1'b0, `LDP_PULSE_FREQUENCY, 16'h0000, 1'b1, g);
    chk({15'h0000, g}, 16'h0000);
    ce = 1'b1;
  endtask
  task s_lock;
    mc = 16'h0BB8;
    get(`LDP_OUTPUT_CURRENT_MEASURED, 16'h0BB8);
    il = 1'b1;
    til = 1'b1;
    get(`LDP_LOCK_FLAGS, 16'h0022);
    il = 1'b0;
    til = 1'b0;
    mb = 16'h0320;
    get(`LDP_LOCK_FLAGS, 16'h0010);
    mb = 16'h0000;
    ot = 1'b1;
    get(`LDP_LOCK_FLAGS, 16'h0018);
    ot = 1'b0;
    oc = 1'b1;
    get(`LDP_LOCK_FLAGS, 16'h0008);
    oc = 1'b0;
  endtask
  // Reply on: a set answers with the raw word while the stored value is clamped
  task s_reply;
    put(`LDP_PROTO_EXT, `LDP_EXT_REPLY_ON, 1'b0);
    put(`LDP_OUTPUT_CURRENT_MAX, 16'hFFFF, 1'b1);
    get(`LDP_OUTPUT_CURRENT_MAX, 16'h0FA0);
    put(`LDP_OUTPUT_CURRENT, 16'hFFFF, 1'b1);
    chk(rd, 16'hFFFF);
    get(`LDP_OUTPUT_CURRENT, 16'h0FA0);
    chk(ocur, 16'h0FA0);
  endtask
  task summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    rst_i = 1'b1;
    {il, til, oc, ot} = 4'h0;
    ce = 1'b1;
    mc = 16'h0000;
    mb = 16'h0000;
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    s_defaults;
    s_limits;
    s_pulse;
    s_state;
    s_save;
    s_errors;
    s_lock;
    s_reply;
    summarize;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #200000;
    failures++;
    summarize;
  end
endmodule // tb
